// ---- logic/brha_pkg.sv ----
package brha_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  // Grant is dropped and re-offered a few clocks after the acknowledge moves
  localparam int GRANT_GAP_CLKS = 2;
  localparam int GAP_W = 2;
  localparam logic [GAP_W-1:0] GAP_RESET = 2'h0;
  localparam logic [GAP_W-1:0] GAP_LOAD = 2'h2;

  // ****************************************
  // Field widths
  // ****************************************
  localparam int ADDR_W = 24;
  localparam int FC_W = 3;
  localparam int SIZE_W = 2;
  localparam int DATA_W = 16;
  localparam logic [2:0] CYC_RESET = 3'h0;

  // ****************************************
  // Types
  // ****************************************
  // Access information replayed on retry and held while halted
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [FC_W-1:0] fc;
    logic [SIZE_W-1:0] size;
    logic read;
  } brha_access_t;

  // Core-side request for one external bus cycle
  typedef struct packed {
    brha_access_t acc;
    logic last;
    logic rmw;
  } brha_req_t;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b000,
    BUS_RUN = 3'b001,
    BUS_RETRY = 3'b010,
    BUS_HALTED = 3'b011,
    BUS_RELEASED = 3'b100
  } brha_bus_state_t;

  typedef enum logic [1:0] {
    ARB_OWN = 2'b00,
    ARB_GRANT = 2'b01,
    ARB_EXT = 2'b10,
    ARB_GAP = 2'b11
  } brha_arb_state_t;

endpackage

// ---- logic/brha_sync.sv ----
`timescale 1ns/1ps
// ****************************************
// Two-stage level synchroniser, one per bit
// ****************************************
module brha_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          meta[g] <= RST_VAL[g];
          q_o[g] <= RST_VAL[g];
        end else if (ce_i) begin
          meta[g] <= d_i[g];
          q_o[g] <= meta[g];
        end
      end
    end
  endgenerate
endmodule // brha_sync

// ---- logic/brha_ctrl.sv ----
`timescale 1ns/1ps
// Behaviour
// [RQ1] Error plus halt during a cycle retries instead of raising an exception.
// [RQ2] Retry ends the cycle, idles controls, waits for error and halt to drop.
// [RQ3] After sync delay, rerun the cycle with the same access information.
// [RQ4] Outside logic drops error before S2 of the retried read.
// [RQ5] Locked sequence retries each cycle alone; lock stays on throughout.
// [RQ6] Request with error and halt: give up bus, retry after regaining it.
// [RQ7] Never release inside locked sequence; error plus request forces that.
// [RQ8] Halt alone stops bus activity after the size acknowledge ends.
// [RQ9] Halt on byte port stops only at operand transfer word boundaries.
// [RQ10] Halt suspends only external cycles; internal work goes on.
// [RQ11] Dropping then raising halt lets exactly one bus cycle through.
// [RQ12] Halted: data floats, controls idle driven, access outputs held.
// [RQ13] Grant still works halted; outputs float, then previous access returns.
// [RQ14] No interrupt acceptance while halted.
// [RQ15] Error during exception processing or frame reload is a double fault.
// [RQ16] Double fault halts, drives halt low, stays until reset; arbitration on.
// [RQ17] Retries and later errors are not double faults; retry without limit.
// [RQ18] Request, grant, acknowledge handshake; device has lowest priority.
// [RQ19] Accept requests anytime; grant only after operand end and lock release.
// [RQ20] Other master takes bus only on grant with acknowledge idle.
// [RQ21] Drop grant a few clocks after acknowledge moves; regrant if pending.
// [RQ22] Requests seen normally, while halted, and after double fault.
// [RQ23] Mastership ends when acknowledge drops; held request means new grant.
// [RQ24] Request and acknowledge are synchronised within two clocks.
// [RQ25] Retry starts on first edge after synced error and halt are idle.
module brha_ctrl
  import brha_pkg::*;
(
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RESET_N_I,
  input wire logic CE_I,
  // Core request side
  input wire brha_pkg::brha_req_t REQ_I,
  input wire logic REQ_VALID_I,
  output logic REQ_READY_O,
  output logic CYCLE_DONE_O,
  output logic BUS_ERROR_EXC_O,
  input wire logic EXC_PROC_I,
  input wire logic ADDR_ERROR_I,
  input wire logic IRQ_PENDING_I,
  output logic IRQ_ACCEPT_O,
  output logic DOUBLE_FAULT_O,
  output logic HALTED_O,
  // External bus pins
  output brha_pkg::brha_access_t ACC_O,
  output logic ACC_OE_N_O,
  output logic STROBE_N_O,
  output logic STROBE_OE_N_O,
  output logic DATA_OE_N_O,
  output logic RMW_LOCK_N_O,
  input wire logic DATA_SIZE_ACK_N_I,
  input wire logic BUS_ERROR_IN_N_I,
  input wire logic HALT_N_I,
  output logic HALT_N_O,
  output logic HALT_OE_N_O,
  // Arbitration pins
  input wire logic BUS_REQUEST_N_I,
  input wire logic GRANT_ACK_N_I,
  output logic BUS_GRANT_N_O
);
  import brha_pkg::*;

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [4:0] raw_in;
  logic [4:0] sync_in;
  assign raw_in = {~BUS_REQUEST_N_I, ~GRANT_ACK_N_I, ~BUS_ERROR_IN_N_I,
                   ~HALT_N_I, ~DATA_SIZE_ACK_N_I};

  brha_sync #(.WIDTH(5), .RST_VAL(5'h00)) u_sync ( // [RQ24]
    .clk_i(MCLK_I),
    .rst_n_i(RESET_N_I),
    .ce_i(CE_I),
    .d_i(raw_in),
    .q_o(sync_in)
  );

  wire req_s = sync_in[4];
  wire ack_s = sync_in[3];
  wire bus_error_in_s = sync_in[2];
  wire halt_s = sync_in[1];
  wire dsack_s = sync_in[0];

  // ****************************************
  // Bus cycle state
  // ****************************************
  brha_bus_state_t state, next_state;
  brha_req_t cur;
  logic dbl_fault;
  logic in_lock;
  logic halt_pending;
  logic grant_ok;
  logic ext_owner;
  brha_arb_state_t arb, next_arb;

  // Termination decode
  wire term_retry = bus_error_in_s & halt_s; // [RQ1]
  wire term_relq = bus_error_in_s & ~halt_s & req_s & cur.rmw; // [RQ7]
  wire term_err = bus_error_in_s & ~halt_s & ~term_relq;
  wire term_ok = dsack_s & ~bus_error_in_s;
  wire running = (state == BUS_RUN);
  // Errors in exception processing or frame reload escalate
  wire fault_evt = (running & term_err & EXC_PROC_I) |
                   (ADDR_ERROR_I & EXC_PROC_I); // [RQ15] [RQ17]
  // Halt only takes effect at an operand boundary
  wire halt_here = halt_s & cur.last; // [RQ9]
  wire grant_due = (arb == ARB_GRANT) |
                   ((arb == ARB_OWN) & req_s & ~ack_s & grant_ok); // [RQ18]
  // Stale acknowledge or error of the last cycle would end the next one early
  wire start_ok = REQ_VALID_I & ~halt_pending & ~dbl_fault & ~ext_owner &
                  ~grant_due & ~dsack_s & ~bus_error_in_s; // [RQ2]

  always_comb begin
    next_state = state;
    unique case (state)
      BUS_IDLE: begin
        if (start_ok) begin
          next_state = BUS_RUN;
        end
      end
      BUS_RUN: begin
        if (term_retry | term_relq) begin
          next_state = BUS_RETRY; // [RQ2] [RQ6]
        end else if (term_err) begin
          next_state = BUS_IDLE;
        end else if (term_ok) begin
          next_state = halt_here ? BUS_HALTED : BUS_IDLE; // [RQ8]
        end
      end
      BUS_RETRY: begin
        // Rerun only with error and halt idle and the bus ours
        if (!bus_error_in_s && !halt_s && !ext_owner && !grant_due && !dbl_fault) begin
          next_state = BUS_RUN; // [RQ3] [RQ25]
        end
      end
      BUS_HALTED: begin
        if (ext_owner) begin
          next_state = BUS_RELEASED; // [RQ13]
        end else if (!halt_s && !dbl_fault) begin
          next_state = BUS_IDLE; // [RQ11]
        end
      end
      BUS_RELEASED: begin
        if (!ext_owner) begin
          next_state = BUS_HALTED;
        end
      end
      default: next_state = BUS_IDLE;
    endcase
    if (fault_evt) begin
      next_state = BUS_HALTED; // [RQ16]
    end
  end

  assign REQ_READY_O = (state == BUS_IDLE) & start_ok;
  assign halt_pending = halt_s & ~in_lock & cur.last; // [RQ9]

  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state <= BUS_IDLE;
      cur <= '{acc: '0, last: 1'b1, rmw: 1'b0};
      dbl_fault <= 1'b0;
    end else if (CE_I) begin
      state <= next_state;
      // Access info is held unchanged across retry and halt
      if (REQ_READY_O) begin
        cur <= REQ_I; // [RQ3] [RQ12]
      end else if (running && term_err) begin
        cur.last <= 1'b1;
      end
      if (fault_evt) begin
        dbl_fault <= 1'b1; // [RQ16]
      end
    end
  end

  // Lock stays set through every error-and-halt retry of a locked sequence; error plus request clears it
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      in_lock <= 1'b0;
    end else if (CE_I) begin
      if (REQ_READY_O) begin
        in_lock <= REQ_I.rmw; // [RQ5]
      end else if (running && term_ok && cur.last) begin
        in_lock <= 1'b0;
      end else if (term_relq && running) begin
        in_lock <= 1'b0; // [RQ7]
      end
    end
  end

  // ****************************************
  // Core-side results
  // ****************************************
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      CYCLE_DONE_O <= 1'b0;
      BUS_ERROR_EXC_O <= 1'b0;
    end else if (CE_I) begin
      CYCLE_DONE_O <= running & term_ok;
      BUS_ERROR_EXC_O <= running & term_err & ~EXC_PROC_I; // [RQ1]
    end
  end

  wire halted_now = (state == BUS_HALTED) | (state == BUS_RELEASED) |
                    dbl_fault | (halt_s & ~running);
  assign HALTED_O = halted_now; // [RQ10]
  assign IRQ_ACCEPT_O = IRQ_PENDING_I & ~halted_now; // [RQ14]
  assign DOUBLE_FAULT_O = dbl_fault;

  // ****************************************
  // Arbiter
  // ****************************************
  logic [GAP_W-1:0] gap_cnt;

  // Grant only between operands and outside a locked sequence
  assign grant_ok = ~in_lock & cur.last & (state != BUS_RUN); // [RQ19] [RQ7]
  assign ext_owner = (arb == ARB_EXT) | (arb == ARB_GAP) | ack_s;

  always_comb begin
    next_arb = arb;
    unique case (arb)
      ARB_OWN: begin
        if (req_s && !ack_s && grant_ok) begin
          next_arb = ARB_GRANT; // [RQ18] [RQ22]
        end
      end
      ARB_GRANT: begin
        if (ack_s) begin
          next_arb = ARB_GAP; // [RQ20] [RQ21]
        end else if (!req_s) begin
          next_arb = ARB_OWN; // Request withdrawn before takeover
        end
      end
      ARB_GAP: begin
        if (gap_cnt == GAP_RESET) begin
          next_arb = ARB_EXT;
        end
      end
      ARB_EXT: begin
        if (req_s) begin
          next_arb = ARB_GRANT; // [RQ23]
        end else if (!ack_s) begin
          next_arb = ARB_OWN; // [RQ23]
        end
      end
    endcase
  end

  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      arb <= ARB_OWN;
      gap_cnt <= GAP_RESET;
    end else if (CE_I) begin
      arb <= next_arb;
      if (arb == ARB_GRANT && ack_s) begin
        gap_cnt <= GAP_LOAD;
      end else if (gap_cnt != GAP_RESET) begin
        gap_cnt <= gap_cnt - 2'h1;
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      BUS_GRANT_N_O <= 1'b1;
    end else if (CE_I) begin
      BUS_GRANT_N_O <= ~(next_arb == ARB_GRANT); // [RQ21]
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  wire floated = ext_owner | (arb == ARB_GRANT & ack_s);
  wire brha_access_t out_acc = REQ_READY_O ? REQ_I.acc : cur.acc; // [RQ3]
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ACC_O <= '0;
      ACC_OE_N_O <= 1'b0;
      STROBE_N_O <= 1'b1;
      STROBE_OE_N_O <= 1'b0;
      DATA_OE_N_O <= 1'b1;
      RMW_LOCK_N_O <= 1'b1;
      HALT_N_O <= 1'b1;
      HALT_OE_N_O <= 1'b1;
    end else if (CE_I) begin
      ACC_O <= out_acc;
      ACC_OE_N_O <= floated; // [RQ13]
      STROBE_OE_N_O <= floated; // [RQ12]
      STROBE_N_O <= ~(next_state == BUS_RUN); // [RQ2] [RQ12]
      DATA_OE_N_O <= ~(next_state == BUS_RUN && !out_acc.read);
      RMW_LOCK_N_O <= ~in_lock | floated; // [RQ5]
      HALT_N_O <= 1'b0;
      HALT_OE_N_O <= ~dbl_fault; // [RQ16]
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_retry_no_exc;
    @(posedge MCLK_I) disable iff (!RESET_N_I)
      (CE_I && running && term_retry) |=> !BUS_ERROR_EXC_O;
  endproperty
  a_retry_no_exc: assert property (p_retry_no_exc) // [RQ1]
    else $error("retry raised a bus error exception");

  property p_retry_waits;
    @(posedge MCLK_I) disable iff (!RESET_N_I)
      (state == BUS_RETRY && (bus_error_in_s || halt_s)) |=> (state != BUS_RUN);
  endproperty
  a_retry_waits: assert property (p_retry_waits) // [RQ2]
    else $error("cycle restarted while error or halt active");

  property p_retry_same;
    @(posedge MCLK_I) disable iff (!RESET_N_I)
      (state == BUS_RETRY) |=> $stable(cur);
  endproperty
  a_retry_same: assert property (p_retry_same) // [RQ3]
    else $error("access information changed during retry");

  property p_retry_start;
    @(posedge MCLK_I) disable iff (!RESET_N_I)
      (CE_I && state == BUS_RETRY && !bus_error_in_s && !halt_s && !ext_owner &&
       !grant_due && !dbl_fault && !fault_evt) |=> (state == BUS_RUN);
  endproperty
  a_retry_start: assert property (p_retry_start) // [RQ25]
    else $error("retry did not start on first clear edge");

  property p_no_grant_locked;
    @(posedge MCLK_I) disable iff (!RESET_N_I)
      (in_lock || running) |-> ##1 (arb != ARB_GRANT || $past(arb) == ARB_GRANT
                                   || $past(arb) == ARB_EXT);
  endproperty
  a_no_grant_locked: assert property (p_no_grant_locked) // [RQ19]
    else $error("grant issued inside lock or cycle");

  property p_dbl_hold;
    @(posedge MCLK_I) disable iff (!RESET_N_I)
      dbl_fault |=> (dbl_fault && !HALT_OE_N_O && !HALT_N_O);
  endproperty
  a_dbl_hold: assert property (p_dbl_hold) // [RQ16]
    else $error("double fault not held with halt driven low");

  property p_no_irq_halted;
    @(posedge MCLK_I) disable iff (!RESET_N_I)
      halted_now |-> !IRQ_ACCEPT_O;
  endproperty
  a_no_irq_halted: assert property (p_no_irq_halted) // [RQ14]
    else $error("interrupt accepted while halted");

  property p_float_ext;
    @(posedge MCLK_I) disable iff (!RESET_N_I)
      (CE_I && arb == ARB_EXT) |=> ACC_OE_N_O;
  endproperty
  a_float_ext: assert property (p_float_ext) // [RQ13]
    else $error("address driven while bus granted away");

  c_retry: cover property (@(posedge MCLK_I) state == BUS_RETRY ##1
                           state == BUS_RUN);
  c_halt: cover property (@(posedge MCLK_I) state == BUS_HALTED);
  c_grant: cover property (@(posedge MCLK_I) arb == ARB_GRANT ##1
                           arb == ARB_GAP);
  c_dbl: cover property (@(posedge MCLK_I) $rose(dbl_fault));

endmodule // brha_ctrl

// ---- testbench/brha_far_end.sv ----
`timescale 1ns/1ps
// ****************************************
// Memory controller and one alternate master
// ****************************************
module brha_far_end (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Bench commands
  input wire logic [1:0] mode_i,
  input wire logic [3:0] lat_i,
  input wire logic halt_i,
  input wire logic want_i,
  // Bus side
  input wire logic strobe_n_i,
  input wire logic grant_n_i,
  output logic ack_n_o,
  output logic err_n_o,
  output logic halt_n_o,
  output logic req_n_o,
  output logic gack_n_o
);
  logic [3:0] cnt;
  logic [3:0] own;
  logic [2:0] hold;
  logic rty;
  logic pend;
  assign halt_n_o = ~(halt_i | rty);
  assign req_n_o = ~pend;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 4'h0;
      hold <= 3'h0;
      rty <= 1'b0;
      ack_n_o <= 1'b1;
      err_n_o <= 1'b1;
    end else if (!strobe_n_i) begin
      cnt <= cnt + 4'h1;
      if (cnt == lat_i) begin
        ack_n_o <= (mode_i != 2'h0);
        err_n_o <= (mode_i == 2'h0);
        rty <= (mode_i == 2'h2);
        hold <= (mode_i == 2'h2) ? 3'h3 : 3'h0;
      end
    end else begin
      // Released lines go back to their pull-up level
      cnt <= 4'h0;
      ack_n_o <= 1'b1;
      if (hold != 3'h0) begin
        hold <= hold - 3'h1;
      end else begin
        err_n_o <= 1'b1;
        rty <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend <= 1'b0;
      own <= 4'h0;
      gack_n_o <= 1'b1;
    end else if (own != 4'h0) begin
      own <= own - 4'h1;
      gack_n_o <= (own == 4'h1);
    end else if (pend && !grant_n_i && gack_n_o) begin
      pend <= 1'b0;
      gack_n_o <= 1'b0;
      own <= 4'h8;
    end else if (want_i) begin
      pend <= 1'b1;
    end
  end
endmodule // brha_far_end

// ---- testbench/test_bus_retry_halt_arbitration.sv ----
`timescale 1ns/1ps
module test_bus_retry_halt_arbitration;
  import brha_pkg::*;
  // ****************************************
  // Wiring
  // ****************************************
  logic mclk, rst_n, valid, exc, aerr, irq, halt_c, want, d, e;
  logic [1:0] mode;
  logic [3:0] lat;
  brha_req_t req, r;
  brha_access_t acc, held;
  logic ready, done, bexc, iacc, dbl, hltd, acc_oe_n, strb_n, strb_oe_n;
  logic doe_n, lock_n, halt_o_n, halt_oe_n, grant_n;
  logic ack_n, err_n, halt_x_n, br_n, gack_n;
  int failures, cmp_count, seed, cycles, i, n;
  wire logic halt_n = halt_x_n & (halt_oe_n | halt_o_n);
  wire logic strobe_w = strb_oe_n | strb_n;

  brha_ctrl dut (.MCLK_I(mclk), .RESET_N_I(rst_n), .CE_I(1'b1),
    .REQ_I(req), .REQ_VALID_I(valid), .REQ_READY_O(ready),
    .CYCLE_DONE_O(done), .BUS_ERROR_EXC_O(bexc), .EXC_PROC_I(exc),
    .ADDR_ERROR_I(aerr), .IRQ_PENDING_I(irq), .IRQ_ACCEPT_O(iacc),
    .DOUBLE_FAULT_O(dbl), .HALTED_O(hltd), .ACC_O(acc),
    .ACC_OE_N_O(acc_oe_n), .STROBE_N_O(strb_n),
    .STROBE_OE_N_O(strb_oe_n), .DATA_OE_N_O(doe_n),
    .RMW_LOCK_N_O(lock_n), .DATA_SIZE_ACK_N_I(ack_n),
    .BUS_ERROR_IN_N_I(err_n), .HALT_N_I(halt_n), .HALT_N_O(halt_o_n),
    .HALT_OE_N_O(halt_oe_n), .BUS_REQUEST_N_I(br_n),
    .GRANT_ACK_N_I(gack_n), .BUS_GRANT_N_O(grant_n));
  brha_far_end far (.clk_i(mclk), .rst_n_i(rst_n), .mode_i(mode),
    .lat_i(lat), .halt_i(halt_c), .want_i(want), .strobe_n_i(strobe_w),
    .grant_n_i(grant_n), .ack_n_o(ack_n), .err_n_o(err_n),
    .halt_n_o(halt_x_n), .req_n_o(br_n), .gack_n_o(gack_n));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string nm, input logic [47:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  function automatic brha_req_t rand_req(input logic rmw);
    brha_req_t q;
    q = $random(seed);
    q.last = 1'b1;
    q.rmw = rmw;
    return q;
  endfunction
  task automatic issue(input brha_req_t q, input logic [1:0] m,
                       input logic [3:0] l);
    @(posedge mclk);
    req <= q;
    valid <= 1'b1;
    mode <= m;
    lat <= l;
    for (n = 0; n < 50 && ready !== 1'b1; n++) @(negedge mclk);
    @(posedge mclk);
    valid <= 1'b0;
    for (n = 0; n < 9 && strobe_w; n++) @(negedge mclk);
    chk("access", acc, q.acc);
  endtask
  task automatic fin(output logic dn, en);
    dn = 1'b0;
    en = 1'b0;
    for (n = 0; n < 60 && !(dn | en); n++) begin
      @(negedge mclk);
      dn = done;
      en = bexc;
    end
  endtask
  task automatic pulse_want();
    @(posedge mclk);
    want <= 1'b1;
    @(posedge mclk);
    want <= 1'b0;
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Run is far below this; a hang ends here
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    seed = 3166;
    {rst_n, valid, exc, aerr, irq, halt_c, want} = '0;
    {mode, lat, failures, cmp_count, cycles} = '0;
    req = '0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    for (i = 0; i < 6; i++) begin
      issue(rand_req(1'b0), 2'h0, 4'($random(seed) & 7));
      fin(d, e);
      chk("done", {d, e}, 2'h2);
    end
    $display("normal cycles finished");
    r = rand_req(1'b1);
    @(posedge mclk);
    exc <= 1'b1;
    issue(r, 2'h2, 4'h1);
    for (i = 0; i < 2; i++) begin
      for (n = 0; n < 20 && !strobe_w; n++) @(negedge mclk);
      @(posedge mclk);
      mode <= (i == 0) ? 2'h2 : 2'h0;
      for (n = 0; n < 20 && !err_n; n++) begin
        @(negedge mclk);
        chk("idle in retry", {strobe_w, lock_n}, 2'b10);
      end
      for (n = 0; n < 9 && strobe_w; n++) @(negedge mclk);
      chk("retried access", acc, r.acc);
    end
    fin(d, e);
    chk("retry end", {d, e, dbl}, 3'b100);
    $display("retry finished");
    @(posedge mclk);
    exc <= 1'b0;
    halt_c <= 1'b1;
    irq <= 1'b1;
    repeat (4) @(posedge mclk);
    req <= rand_req(1'b0);
    valid <= 1'b1;
    @(negedge mclk);
    held = acc;
    for (i = 0; i < 8; i++) begin
      @(negedge mclk);
      chk("halted", {ready, strobe_w, doe_n}, 3'h3);
      chk("no irq", {hltd, iacc}, 2'h2);
      chk("held access", acc, held);
    end
    pulse_want();
    for (n = 0; n < 20 && gack_n; n++) @(negedge mclk);
    repeat (3) @(negedge mclk);
    chk("float", {gack_n, acc_oe_n, strb_oe_n}, 3'b011);
    for (n = 0; n < 20 && !gack_n; n++) @(negedge mclk);
    repeat (6) @(negedge mclk);
    chk("restored", {acc_oe_n, acc}, {1'b0, held});
    @(posedge mclk);
    halt_c <= 1'b0;
    for (n = 0; n < 20 && ready !== 1'b1; n++) @(negedge mclk);
    @(posedge mclk);
    halt_c <= 1'b1;
    req <= rand_req(1'b0);
    i = 1;
    for (n = 0; n < 30; n++) begin
      @(negedge mclk);
      if (ready === 1'b1) i++;
    end
    chk("single step", i, 1);
    @(posedge mclk);
    halt_c <= 1'b0;
    irq <= 1'b0;
    for (n = 0; n < 20 && ready !== 1'b1; n++) @(negedge mclk);
    @(posedge mclk);
    valid <= 1'b0;
    fin(d, e);
    chk("resume", {d, e}, 2'b10);
    $display("halt finished");
    issue(rand_req(1'b0), 2'h0, 4'h6);
    pulse_want();
    for (n = 0; n < 20 && !strobe_w; n++) begin
      @(negedge mclk);
      chk("no grant in cycle", grant_n, 1'b1);
    end
    for (n = 0; n < 10 && grant_n; n++) @(negedge mclk);
    chk("grant", {grant_n, br_n}, 2'b00);
    for (n = 0; n < 10 && gack_n; n++) @(negedge mclk);
    for (n = 0; n < GRANT_GAP_CLKS + 4 && !grant_n; n++) @(negedge mclk);
    chk("grant dropped", {gack_n, grant_n}, 2'b01);
    for (n = 0; n < 20 && !gack_n; n++) @(negedge mclk);
    $display("arbitration finished");
    issue(rand_req(1'b1), 2'h1, 4'h6);
    pulse_want();
    for (n = 0; n < 20 && gack_n; n++) @(negedge mclk);
    @(posedge mclk);
    mode <= 2'h0;
    repeat (3) @(negedge mclk);
    chk("relinquish", {lock_n, acc_oe_n, strb_oe_n}, 3'h7);
    fin(d, e);
    chk("retry after regain", {d, e}, 2'h2);
    $display("relinquish finished");
    issue(rand_req(1'b0), 2'h1, 4'h0);
    fin(d, e);
    chk("bus error", {d, e, dbl}, 3'b010);
    @(posedge mclk);
    exc <= 1'b1;
    aerr <= 1'b1;
    @(posedge mclk);
    aerr <= 1'b0;
    repeat (3) @(negedge mclk);
    chk("double fault", {dbl, halt_oe_n, halt_n, hltd}, 4'b1001);
    pulse_want();
    for (n = 0; n < 20 && grant_n; n++) @(negedge mclk);
    chk("grant after fault", {grant_n, dbl}, 2'b01);
    $display("double fault finished");
    report_and_stop();
  end
endmodule // test_bus_retry_halt_arbitration
